// [hw/rpa_regs.svh]
// What this block does
// R01: Controller copies current count into set count
// R02: Assembly outputs obeyed only while counts match
// R03: Input words stay live while counts differ
// R04: Mismatched counts discard assembly control writes
// R05: Full output assembly: 27 words from 3800
// R06: Reduced input assembly: nine words from 4700
// R07: Reduced output assembly: nine words from 4800
// R08: Reset count words live only in assemblies
// R09: Digital control writes, same address reads status
// R10: Controller accumulate command lost at restart
// R11: Nonvolatile accumulate setting holds zone at power-up
// R12: Port digital outputs only with control bit 15
// R13: Restart loads fresh current count
`ifndef RPA_REGS_SVH
`define RPA_REGS_SVH

// Assembly bases and sizes (holding register numbers)
`define RPA_FULL_OUT_BASE   16'd3800
`define RPA_FULL_OUT_WORDS  16'd27
`define RPA_FULL_SETCNT     16'd22
`define RPA_RED_IN_BASE     16'd4700
`define RPA_RED_OUT_BASE    16'd4800
`define RPA_RED_WORDS       16'd9
`define RPA_RED_CNT         16'd8

// Internal addresses of the control words, in full assembly order
`define RPA_A_STOP          16'd20
`define RPA_A_LEFT_DIO      16'd60
`define RPA_A_RIGHT_DIO     16'd84
`define RPA_A_CPORT_OUT     16'd37
`define RPA_A_LEFT_RUN      16'd260
`define RPA_A_LEFT_BRAKE    16'd261
`define RPA_A_LEFT_SPDM     16'd262
`define RPA_A_RIGHT_RUN     16'd270
`define RPA_A_RIGHT_BRAKE   16'd271
`define RPA_A_RIGHT_SPDM    16'd272
`define RPA_A_LEFT_SPEED    16'd40
`define RPA_A_RIGHT_SPEED   16'd64
`define RPA_A_LEFT_ACCEL    16'd43
`define RPA_A_LEFT_DECEL    16'd44
`define RPA_A_RIGHT_ACCEL   16'd67
`define RPA_A_RIGHT_DECEL   16'd68
`define RPA_A_ERR_CLEAR     16'd22
`define RPA_A_STAT_DOWN     16'd196
`define RPA_A_STAT_UP       16'd116
`define RPA_A_SENSOR_MASK   16'd34
`define RPA_A_TRACK_LO      16'd201
`define RPA_A_TRACK_HI      16'd202
`define RPA_A_LSERVO_PULSE  16'd8
`define RPA_A_LSERVO_WORD   16'd9
`define RPA_A_RSERVO_PULSE  16'd13
`define RPA_A_RSERVO_WORD   16'd14

// Internal addresses of the live status words, in reduced input order
`define RPA_A_SENSOR_CTRL   16'd35
`define RPA_A_SENSOR_DET    16'd36
`define RPA_A_LEFT_TEMP     16'd57
`define RPA_A_LEFT_STATE    16'd58
`define RPA_A_RIGHT_TEMP    16'd81
`define RPA_A_RIGHT_STATE   16'd82

// Zone mode words and their accumulate bit
`define RPA_A_ZONE_UP_MODE  16'd365
`define RPA_A_ZONE_DN_MODE  16'd375
`define RPA_ZONE_ACCUM_BIT  0

// Motor port digital field positions
`define RPA_DIO_ENABLE_BIT  15
`define RPA_DIO_SHORT_BIT   12
`define RPA_DIO_STAT_BIT    14

// Reset values
`define RPA_CTRL_RESET      16'h0000
`define RPA_SETCNT_RESET    16'h0000
`define RPA_CURCNT_RESET    16'h0000

`endif

// [hw/rpa_pkg.sv]
package rpa_pkg;

    typedef logic [15:0] rpa_word_t;

    // Which storage an address resolves to
    typedef enum logic [2:0] {
        RK_NONE,
        RK_CTRL,
        RK_STAT,
        RK_SETCNT,
        RK_CURCNT,
        RK_ZONE
    } rpa_kind_e;

endpackage

// [hw/rpa_dio_if.sv]
`timescale 1ns/1ns
interface rpa_dio_if;
    import rpa_pkg::*;

    rpa_word_t  ctrl_word;
    rpa_word_t  raw_status;
    logic [2:0] dout;
    rpa_word_t  status_word;

    modport owner (
        output ctrl_word,
        output raw_status,
        input  dout,
        input  status_word
    );

    modport port (
        input  ctrl_word,
        input  raw_status,
        output dout,
        output status_word
    );
endinterface

// [hw/rpa_port_dio.sv]
`timescale 1ns/1ns
`include "rpa_regs.svh"
module rpa_port_dio
    import rpa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control and status of one motor port
    rpa_dio_if.port  dio
);

    logic enabled;

    assign enabled = dio.ctrl_word[`RPA_DIO_ENABLE_BIT];

    // Without the enable bit the port stays a motor port
    always_ff @(posedge clk) begin
        if (srst) begin
            dio.dout <= 3'h0;
        end else begin
            dio.dout <= enabled ? dio.ctrl_word[2:0] : 3'h0; // R12
        end
    end

    // Short and output status carry no meaning unless enabled
    always_ff @(posedge clk) begin
        if (srst) begin
            dio.status_word <= 16'h0000;
        end else begin
            dio.status_word <= dio.raw_status;
            if (!enabled) begin
                dio.status_word[`RPA_DIO_SHORT_BIT] <= 1'b0; // R12
                dio.status_word[`RPA_DIO_STAT_BIT]  <= 1'b0; // R12
            end
        end
    end

endmodule

// [hw/rpa_assembly.sv]
`timescale 1ns/1ns
`include "rpa_regs.svh"
module rpa_assembly
    import rpa_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Holding register port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic            reg_ack,
    output logic            reg_err,
    output logic [15:0]     reg_rdata,
    // Boot counter value supplied at each restart
    input  wire logic [15:0] restart_seed,
    // Nonvolatile accumulate settings, bit 0 upstream zone
    input  wire logic [1:0] nv_accum,
    // Live status
    input  wire logic [15:0] sensor_control_in,
    input  wire logic [15:0] sensor_detect_in,
    input  wire logic [15:0] left_temp_in,
    input  wire logic [15:0] left_state_in,
    input  wire logic [15:0] right_temp_in,
    input  wire logic [15:0] right_state_in,
    input  wire logic [15:0] left_dio_raw,
    input  wire logic [15:0] right_dio_raw,
    // Control outputs
    output rpa_word_t       ctrl_q [26],
    output logic [2:0]      left_dio_out,
    output logic [2:0]      right_dio_out,
    output logic [1:0]      zone_accum,
    output logic            outputs_live
);

    localparam int NCTRL = 26;
    localparam int NSTAT = 8;

    // Control word order follows the full output assembly
    function automatic rpa_word_t ctrl_addr(input logic [4:0] i);
        unique case (i)
            5'd0:    ctrl_addr = `RPA_A_STOP;
            5'd1:    ctrl_addr = `RPA_A_LEFT_DIO;
            5'd2:    ctrl_addr = `RPA_A_RIGHT_DIO;
            5'd3:    ctrl_addr = `RPA_A_CPORT_OUT;
            5'd4:    ctrl_addr = `RPA_A_LEFT_RUN;
            5'd5:    ctrl_addr = `RPA_A_LEFT_BRAKE;
            5'd6:    ctrl_addr = `RPA_A_LEFT_SPDM;
            5'd7:    ctrl_addr = `RPA_A_RIGHT_RUN;
            5'd8:    ctrl_addr = `RPA_A_RIGHT_BRAKE;
            5'd9:    ctrl_addr = `RPA_A_RIGHT_SPDM;
            5'd10:   ctrl_addr = `RPA_A_LEFT_SPEED;
            5'd11:   ctrl_addr = `RPA_A_RIGHT_SPEED;
            5'd12:   ctrl_addr = `RPA_A_LEFT_ACCEL;
            5'd13:   ctrl_addr = `RPA_A_LEFT_DECEL;
            5'd14:   ctrl_addr = `RPA_A_RIGHT_ACCEL;
            5'd15:   ctrl_addr = `RPA_A_RIGHT_DECEL;
            5'd16:   ctrl_addr = `RPA_A_ERR_CLEAR;
            5'd17:   ctrl_addr = `RPA_A_STAT_DOWN;
            5'd18:   ctrl_addr = `RPA_A_STAT_UP;
            5'd19:   ctrl_addr = `RPA_A_SENSOR_MASK;
            5'd20:   ctrl_addr = `RPA_A_TRACK_LO;
            5'd21:   ctrl_addr = `RPA_A_TRACK_HI;
            5'd22:   ctrl_addr = `RPA_A_LSERVO_PULSE;
            5'd23:   ctrl_addr = `RPA_A_LSERVO_WORD;
            5'd24:   ctrl_addr = `RPA_A_RSERVO_PULSE;
            5'd25:   ctrl_addr = `RPA_A_RSERVO_WORD;
            default: ctrl_addr = 16'hffff;
        endcase
    endfunction

    // Status word order follows the reduced input assembly
    function automatic rpa_word_t stat_addr(input logic [2:0] i);
        unique case (i)
            3'd0: stat_addr = `RPA_A_SENSOR_CTRL;
            3'd1: stat_addr = `RPA_A_SENSOR_DET;
            3'd2: stat_addr = `RPA_A_LEFT_TEMP;
            3'd3: stat_addr = `RPA_A_LEFT_STATE;
            3'd4: stat_addr = `RPA_A_RIGHT_TEMP;
            3'd5: stat_addr = `RPA_A_RIGHT_STATE;
            3'd6: stat_addr = `RPA_A_LEFT_DIO;
            3'd7: stat_addr = `RPA_A_RIGHT_DIO;
        endcase
    endfunction

    // Reduced output slot to control word index
    function automatic logic [4:0] red_out_idx(input logic [3:0] s);
        unique case (s)
            4'd0:    red_out_idx = 5'd1;
            4'd1:    red_out_idx = 5'd2;
            4'd2:    red_out_idx = 5'd3;
            4'd3:    red_out_idx = 5'd4;
            4'd4:    red_out_idx = 5'd7;
            4'd5:    red_out_idx = 5'd10;
            4'd6:    red_out_idx = 5'd11;
            default: red_out_idx = 5'd16;
        endcase
    endfunction

    rpa_word_t  stat_q [6];
    rpa_word_t  stat_all [NSTAT];
    rpa_word_t  set_count;
    rpa_word_t  cur_count;
    logic       count_armed;
    logic [1:0] zone_cmd;
    logic [1:0] nv_accum_q;
    logic       prot_ok;

    rpa_word_t  full_off;
    rpa_word_t  rin_off;
    rpa_word_t  rout_off;
    rpa_kind_e  rd_kind;
    rpa_kind_e  wr_kind;
    logic [4:0] rd_idx;
    logic [4:0] wr_idx;
    logic       wr_asm;
    logic       wr_take;
    logic       rd_zone;

    rpa_dio_if  left_if ();
    rpa_dio_if  right_if ();

    assign full_off = reg_addr - `RPA_FULL_OUT_BASE;
    assign rin_off  = reg_addr - `RPA_RED_IN_BASE;
    assign rout_off = reg_addr - `RPA_RED_OUT_BASE;

    // Handshake of the counts; no match until a fresh count is loaded
    assign prot_ok      = count_armed && (set_count == cur_count); // R02
    assign outputs_live = prot_ok;

    // Read decode: shared digital addresses answer with status
    always_comb begin
        rd_kind = RK_NONE;
        rd_idx  = 5'd0;
        rd_zone = 1'b0;
        for (int i = 0; i < NCTRL; i++) begin
            if (reg_addr == ctrl_addr(5'(i))) begin
                rd_kind = RK_CTRL;
                rd_idx  = 5'(i);
            end
        end
        for (int i = 0; i < NSTAT; i++) begin
            if (reg_addr == stat_addr(3'(i))) begin
                rd_kind = RK_STAT; // R09
                rd_idx  = 5'(i);
            end
        end
        if (reg_addr == `RPA_A_ZONE_UP_MODE
                || reg_addr == `RPA_A_ZONE_DN_MODE) begin
            rd_kind = RK_ZONE;
            rd_zone = (reg_addr == `RPA_A_ZONE_DN_MODE);
        end
        if (reg_addr >= `RPA_FULL_OUT_BASE
                && full_off < `RPA_FULL_OUT_WORDS) begin // R05
            if (full_off == `RPA_FULL_SETCNT) begin
                rd_kind = RK_SETCNT; // R08
            end else if (full_off < `RPA_FULL_SETCNT) begin
                rd_kind = RK_CTRL;
                rd_idx  = full_off[4:0];
            end else begin
                rd_kind = RK_CTRL;
                rd_idx  = 5'(full_off - 16'd1);
            end
        end
        if (reg_addr >= `RPA_RED_IN_BASE
                && rin_off < `RPA_RED_WORDS) begin // R06
            if (rin_off == `RPA_RED_CNT) begin
                rd_kind = RK_CURCNT; // R08
            end else begin
                rd_kind = RK_STAT;
                rd_idx  = rin_off[4:0];
            end
        end
        if (reg_addr >= `RPA_RED_OUT_BASE
                && rout_off < `RPA_RED_WORDS) begin // R07
            if (rout_off == `RPA_RED_CNT) begin
                rd_kind = RK_SETCNT; // R08
            end else begin
                rd_kind = RK_CTRL;
                rd_idx  = red_out_idx(rout_off[3:0]);
            end
        end
    end

    // Write decode: the reset counts have no internal address
    always_comb begin
        wr_kind = RK_NONE;
        wr_idx  = 5'd0;
        wr_asm  = 1'b0;
        for (int i = 0; i < NCTRL; i++) begin
            if (reg_addr == ctrl_addr(5'(i))) begin
                wr_kind = RK_CTRL; // R09
                wr_idx  = 5'(i);
            end
        end
        if (reg_addr == `RPA_A_ZONE_UP_MODE
                || reg_addr == `RPA_A_ZONE_DN_MODE) begin
            wr_kind = RK_ZONE;
        end
        if (reg_addr >= `RPA_FULL_OUT_BASE
                && full_off < `RPA_FULL_OUT_WORDS) begin // R05
            wr_asm = 1'b1;
            if (full_off == `RPA_FULL_SETCNT) begin
                wr_kind = RK_SETCNT; // R08
            end else if (full_off < `RPA_FULL_SETCNT) begin
                wr_kind = RK_CTRL;
                wr_idx  = full_off[4:0];
            end else begin
                wr_kind = RK_CTRL;
                wr_idx  = 5'(full_off - 16'd1);
            end
        end
        if (reg_addr >= `RPA_RED_OUT_BASE
                && rout_off < `RPA_RED_WORDS) begin // R07
            wr_asm = 1'b1;
            if (rout_off == `RPA_RED_CNT) begin
                wr_kind = RK_SETCNT; // R08
            end else begin
                wr_kind = RK_CTRL;
                wr_idx  = red_out_idx(rout_off[3:0]);
            end
        end
    end

    // Assembly control writes are dropped while the counts differ
    assign wr_take = reg_wr && (!wr_asm || prot_ok); // R04

    // Control words
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < NCTRL; i++) begin
                ctrl_q[i] <= `RPA_CTRL_RESET;
            end
        end else if (wr_take && wr_kind == RK_CTRL) begin
            ctrl_q[wr_idx] <= reg_wdata; // R02
        end
    end

    // The set count is always writable, else the handshake could lock
    always_ff @(posedge clk) begin
        if (srst) begin
            set_count <= `RPA_SETCNT_RESET;
        end else if (reg_wr && wr_kind == RK_SETCNT) begin
            set_count <= reg_wdata; // R01
        end
    end

    // Fresh count one edge after reset release, never equal to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            cur_count   <= `RPA_CURCNT_RESET;
            count_armed <= 1'b0;
        end else if (!count_armed) begin
            cur_count   <= (restart_seed == 16'hffff) ? 16'h0001
                           : restart_seed + 16'h0001; // R13
            count_armed <= 1'b1;
        end
    end

    // Live status sampled every cycle, whatever the counts show
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < 6; i++) begin
                stat_q[i] <= 16'h0000;
            end
        end else begin
            stat_q[0] <= sensor_control_in; // R03
            stat_q[1] <= sensor_detect_in;
            stat_q[2] <= left_temp_in;
            stat_q[3] <= left_state_in;
            stat_q[4] <= right_temp_in;
            stat_q[5] <= right_state_in;
        end
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            stat_all[i] = stat_q[i];
        end
        stat_all[6] = left_if.status_word;
        stat_all[7] = right_if.status_word;
    end

    // Controller accumulate is plain flop state, gone after a restart
    always_ff @(posedge clk) begin
        if (srst) begin
            zone_cmd <= 2'b00; // R10
        end else if (wr_take && wr_kind == RK_ZONE) begin
            if (reg_addr == `RPA_A_ZONE_DN_MODE) begin
                zone_cmd[1] <= reg_wdata[`RPA_ZONE_ACCUM_BIT];
            end else begin
                zone_cmd[0] <= reg_wdata[`RPA_ZONE_ACCUM_BIT];
            end
        end
    end

    // Stored setting comes from flash, so it holds from power-up on
    always_ff @(posedge clk) begin
        if (srst) begin
            nv_accum_q <= 2'b00;
        end else begin
            nv_accum_q <= nv_accum; // R11
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            zone_accum <= 2'b00;
        end else begin
            zone_accum <= nv_accum_q | zone_cmd; // R11
        end
    end

    // Motor port digital units
    always_comb begin
        left_if.ctrl_word   = ctrl_q[1];
        left_if.raw_status  = left_dio_raw;
        right_if.ctrl_word  = ctrl_q[2];
        right_if.raw_status = right_dio_raw;
    end

    rpa_port_dio u_left_dio (
        .clk  (clk),
        .srst (srst),
        .dio  (left_if.port)
    );

    rpa_port_dio u_right_dio (
        .clk  (clk),
        .srst (srst),
        .dio  (right_if.port)
    );

    assign left_dio_out  = left_if.dout;
    assign right_dio_out = right_if.dout;

    // Register port answer, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_ack   <= 1'b0;
            reg_err   <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            reg_ack   <= reg_wr || reg_rd;
            reg_err   <= 1'b0;
            reg_rdata <= 16'h0000;
            if (reg_wr) begin
                reg_err <= (wr_kind == RK_NONE);
            end else if (reg_rd) begin
                reg_err <= (rd_kind == RK_NONE);
                unique case (rd_kind)
                    RK_CTRL:   reg_rdata <= ctrl_q[rd_idx];
                    RK_STAT:   reg_rdata <= stat_all[rd_idx[2:0]];
                    RK_SETCNT: reg_rdata <= set_count;
                    RK_CURCNT: reg_rdata <= cur_count; // R08
                    RK_ZONE:   reg_rdata <= {15'h0000, zone_cmd[rd_zone]};
                    RK_NONE:   reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule

// [testbench/rpa_assembly_chk.sv]
`timescale 1ns/1ns
`include "rpa_regs.svh"
module rpa_assembly_chk
    import rpa_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_ack,
    input wire logic        reg_err,
    input wire logic [15:0] reg_rdata,
    // Status and control
    input wire logic [15:0] sensor_control_in,
    input wire rpa_word_t   ctrl_q [26],
    input wire logic [2:0]  left_dio_out,
    input wire logic        outputs_live
);
    localparam logic [15:0] fo = `RPA_FULL_OUT_BASE;
    localparam logic [15:0] ri = `RPA_RED_IN_BASE;
    localparam logic [15:0] ro = `RPA_RED_OUT_BASE;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_in_ro;
        (reg_wr && reg_addr >= ri && reg_addr <= ri + 16'h0008)
            |=> (reg_ack && reg_err);
    endproperty
    a_in_ro: assert property (p_in_ro)
        else $error("input assembly write not refused");

    property p_gate;
        (reg_wr && reg_addr == fo && !outputs_live)
            |=> ($stable(ctrl_q[0]) && reg_ack && !reg_err);
    endproperty
    a_gate: assert property (p_gate)
        else $error("write taken while counts differ");

    property p_full;
        (reg_wr && reg_addr == fo + 16'h001a && outputs_live)
            |=> ctrl_q[25] == $past(reg_wdata);
    endproperty
    a_full: assert property (p_full)
        else $error("last full output word not stored");

    property p_red;
        (reg_wr && reg_addr == ro + 16'h0005 && outputs_live)
            |=> ctrl_q[10] == $past(reg_wdata);
    endproperty
    a_red: assert property (p_red)
        else $error("reduced speed word not stored");

    // Only a set count write may arm the outputs
    property p_live_rise;
        $rose(outputs_live) |-> $past(reg_wr)
            && ($past(reg_addr) == fo + 16'h0016
                || $past(reg_addr) == ro + 16'h0008);
    endproperty
    a_live_rise: assert property (p_live_rise)
        else $error("outputs armed without count write");

    property p_live_hold;
        (outputs_live && !(reg_wr && (reg_addr == fo + 16'h0016 ||
            reg_addr == ro + 16'h0008))) |=> outputs_live;
    endproperty
    a_live_hold: assert property (p_live_hold)
        else $error("outputs disarmed while counts match");

    property p_sensor;
        (!$past(srst) && reg_rd && reg_addr == ri)
            |=> reg_rdata == $past(sensor_control_in, 2);
    endproperty
    a_sensor: assert property (p_sensor)
        else $error("input word not live");

    // Two quiet cycles cover the one register stage on the port output
    property p_dio;
        (ctrl_q[1] == $past(ctrl_q[1]) && ctrl_q[1] == $past(ctrl_q[1], 2))
            |-> left_dio_out == (ctrl_q[1][15] ? ctrl_q[1][2:0] : 3'h0);
    endproperty
    a_dio: assert property (p_dio)
        else $error("port output not gated by enable bit");

    c_live: cover property ($rose(outputs_live));
    c_drop: cover property (reg_wr && reg_addr == fo && !outputs_live);
    c_dio: cover property (left_dio_out != 3'h0);
endmodule

bind rpa_assembly rpa_assembly_chk i_chk (
    .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
    .reg_err(reg_err), .reg_rdata(reg_rdata),
    .sensor_control_in(sensor_control_in), .ctrl_q(ctrl_q),
    .left_dio_out(left_dio_out), .outputs_live(outputs_live)
);

// [testbench/rpa_plc_model.sv]
`timescale 1ns/1ns
`include "rpa_regs.svh"
module rpa_plc_model (
    // Clock
    input wire logic        clk,
    // Register port, controller side
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [15:0]     reg_addr,
    output logic [15:0]     reg_wdata,
    input wire logic        reg_ack,
    input wire logic        reg_err,
    input wire logic [15:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end

    // One strobe cycle; the answer is taken one edge after the taking edge
    task automatic xfer(input logic w, input logic [15:0] a, d,
                        output logic [15:0] q, output logic e, k);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // Released lines show the inverse so a stale value cannot match
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(posedge clk);
        k = reg_ack;
        q = reg_rdata;
        e = reg_err;
    endtask

    // Copy the live count into the set count to have outputs obeyed
    task automatic arm(input logic full);
        logic [15:0] q;
        logic [15:0] dummy;
        logic        e;
        logic        k;
        xfer(1'b0, `RPA_RED_IN_BASE + `RPA_RED_CNT, 16'h0000, q, e, k);
        xfer(1'b1, full ? `RPA_FULL_OUT_BASE + `RPA_FULL_SETCNT
                        : `RPA_RED_OUT_BASE + `RPA_RED_CNT,
             q, dummy, e, k);
    endtask
endmodule

// [testbench/reset_protected_io_assembly_tb.sv]
`timescale 1ns/1ns
`include "rpa_regs.svh"
module reset_protected_io_assembly_tb
    import rpa_pkg::*;
;
    localparam logic [15:0] fo = `RPA_FULL_OUT_BASE;
    localparam logic [15:0] ri = `RPA_RED_IN_BASE;
    localparam logic [15:0] ro = `RPA_RED_OUT_BASE;
    localparam logic [15:0] nil = 16'h0000;

    logic        clk;
    logic        srst;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_ack;
    logic        reg_err;
    logic [15:0] reg_rdata;
    logic [15:0] seed;
    logic [1:0]  nv;
    logic [15:0] st [8];
    rpa_word_t   ctrl_q [26];
    logic [2:0]  left_dio_out;
    logic [2:0]  right_dio_out;
    logic [1:0]  zone_accum;
    logic        outputs_live;
    logic [15:0] q;
    logic        e;
    logic        k;
    int          errors;
    int          total_checks;
    int          red_map [8] = '{1, 2, 3, 4, 7, 10, 11, 16};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    rpa_assembly i_dut (
        .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .reg_rdata(reg_rdata), .restart_seed(seed),
        .nv_accum(nv), .sensor_control_in(st[0]), .sensor_detect_in(st[1]),
        .left_temp_in(st[2]), .left_state_in(st[3]), .right_temp_in(st[4]),
        .right_state_in(st[5]), .left_dio_raw(st[6]), .right_dio_raw(st[7]),
        .ctrl_q(ctrl_q), .left_dio_out(left_dio_out),
        .right_dio_out(right_dio_out), .zone_accum(zone_accum),
        .outputs_live(outputs_live)
    );

    rpa_plc_model i_plc (
        .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_err(reg_err),
        .reg_rdata(reg_rdata)
    );

    task automatic chk(input logic [15:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] a, d, x,
                       input logic xe);
        i_plc.xfer(w, a, d, q, e, k);
        chk({15'h0, k}, 16'h0001, "ack");
        chk({15'h0, e}, {15'h0, xe}, "err flag");
        if (!w) chk(q, x, "read data");
    endtask

    task automatic do_reset(input logic [15:0] s);
        @(posedge clk);
        srst <= 1'b1;
        seed <= s;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("unexpected at %0t: run hung", $time);
        finish_test;
    end

    initial begin
        srst = 1'b1;
        seed = 16'h1234;
        nv = 2'b01;
        foreach (st[i]) st[i] = 16'h0a00 + 16'(i);
        do_reset(16'h1234);
        chk({14'h0, zone_accum}, 16'h0001, "stored accumulate");
        chk({15'h0, outputs_live}, nil, "live after boot");
        acc(1'b0, ri + 16'h0008, nil, 16'h1235, 1'b0);
        for (int i = 0; i < 6; i++)
            acc(1'b0, ri + 16'(i), nil, st[i], 1'b0);
        acc(1'b1, fo, 16'h00a5, nil, 1'b0);
        acc(1'b1, ro + 16'h0005, 16'h00a5, nil, 1'b0);
        chk(ctrl_q[0], nil, "full write gated");
        chk(ctrl_q[10], nil, "reduced write gated");
        acc(1'b1, ri, 16'h0001, nil, 1'b1);
        acc(1'b0, nil, nil, nil, 1'b1);
        i_plc.arm(1'b1);
        chk({15'h0, outputs_live}, 16'h0001, "armed");
        for (int i = 0; i < 27; i++) begin
            if (i != 22) begin
                acc(1'b1, fo + 16'(i), 16'h1000 + 16'(i), nil, 1'b0);
                chk(ctrl_q[i - (i > 22)], 16'h1000 + 16'(i), "full");
            end
        end
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, ro + 16'(i), 16'h2000 + 16'(i), nil, 1'b0);
            chk(ctrl_q[red_map[i]], 16'h2000 + 16'(i), "reduced");
        end
        st[6] <= 16'h5007;
        acc(1'b1, `RPA_A_LEFT_DIO, 16'h8005, nil, 1'b0);
        acc(1'b1, `RPA_A_RIGHT_DIO, 16'h8003, nil, 1'b0);
        repeat (3) @(posedge clk);
        chk({13'h0, left_dio_out}, 16'h0005, "left port out");
        chk({13'h0, right_dio_out}, 16'h0003, "right port out");
        acc(1'b0, `RPA_A_LEFT_DIO, nil, 16'h5007, 1'b0);
        acc(1'b0, ri + 16'h0006, nil, 16'h5007, 1'b0);
        acc(1'b1, `RPA_A_LEFT_DIO, 16'h0005, nil, 1'b0);
        repeat (3) @(posedge clk);
        chk({13'h0, left_dio_out}, nil, "left port off");
        acc(1'b0, `RPA_A_LEFT_DIO, nil, 16'h0007, 1'b0);
        acc(1'b1, `RPA_A_ZONE_DN_MODE, 16'h0001, nil, 1'b0);
        repeat (3) @(posedge clk);
        chk({14'h0, zone_accum}, 16'h0003, "commanded accumulate");
        acc(1'b0, `RPA_A_ZONE_DN_MODE, nil, 16'h0001, 1'b0);
        nv <= 2'b10;
        do_reset(16'hffff);
        chk({14'h0, zone_accum}, 16'h0002, "nv accumulate");
        acc(1'b0, `RPA_A_ZONE_DN_MODE, nil, nil, 1'b0);
        acc(1'b0, ri + 16'h0008, nil, 16'h0001, 1'b0);
        acc(1'b1, fo + 16'h0016, 16'h1235, nil, 1'b0);
        chk({15'h0, outputs_live}, nil, "stale count");
        acc(1'b1, fo, 16'h0077, nil, 1'b0);
        chk(ctrl_q[0], nil, "stale write dropped");
        i_plc.arm(1'b0);
        acc(1'b1, fo, 16'h0077, nil, 1'b0);
        chk(ctrl_q[0], 16'h0077, "rearmed write");
        finish_test;
    end
endmodule
